//--- rtl/rss_pkg.sv
/*
 Constants for the radio sleep and settings control block: register
 indices, reset values, valid ranges, mode codes and tick counts.
 Assumes a 40 MHz device clock.
*/
// Function
// RULE_01: Transmit power level zero to four, reset four.
// RULE_02: High power variant recalibrates every fifteen seconds.
// RULE_03: Boost select bit, reset one.
// RULE_04: Cancel transmission when channel energy exceeds threshold.
// RULE_05: Threshold range 0x28 to 0x50, reset 0x2C.
// RULE_06: Sleep modes 0,1,4,5; reserved codes rejected.
// RULE_07: Sleep disabled keeps device idle and receiving.
// RULE_08: Awake window in ms, 1 to 0xFFFF.
// RULE_09: Cyclic sleep period in 10 ms units.
// RULE_10: Coordinator discards held message after 2.5 periods.
// RULE_11: Zero sleep period on coordinator sends directly.
// RULE_12: Unjoined remote sleeps unjoined period before retrying.
// RULE_13: Option bit 0x01 skips wakeup poll.
// RULE_14: Option bit 0x02 skips wakeup sample.
// RULE_15: Baud request stores nearest achievable rate.
// RULE_16: Baud setting never touches radio data rate.
// RULE_17: Host programs equal awake windows everywhere.
// RULE_18: Awake timer starts, restarts on activity, then sleep.
package rss_pkg;
  localparam logic [3:0] REG_TX_POWER = 4'h0;
  localparam logic [3:0] REG_GAIN = 4'h1;
  localparam logic [3:0] REG_CCA = 4'h2;
  localparam logic [3:0] REG_SLEEP_MODE = 4'h3;
  localparam logic [3:0] REG_AWAKE = 4'h4;
  localparam logic [3:0] REG_SLEEP_PER = 4'h5;
  localparam logic [3:0] REG_UNJOINED = 4'h6;
  localparam logic [3:0] REG_OPTIONS = 4'h7;
  localparam logic [3:0] REG_BAUD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [2:0] TX_POWER_RST = 3'h4;
  localparam logic [2:0] TX_POWER_MAX = 3'h4;
  localparam logic GAIN_RST = 1'h1;
  localparam logic [7:0] CCA_RST = 8'h2C;
  localparam logic [7:0] CCA_MIN = 8'h28;
  localparam logic [7:0] CCA_MAX = 8'h50;
  localparam logic [2:0] SM_NONE = 3'h0;
  localparam logic [2:0] SM_PIN = 3'h1;
  localparam logic [2:0] SM_CYCLIC = 3'h4;
  localparam logic [2:0] SM_CYCLIC_PIN = 3'h5;
  localparam logic [15:0] AWAKE_RST = 16'h1388;
  localparam logic [23:0] SLEEP_PER_RST = 24'h000000;
  localparam logic [23:0] SLEEP_PER_MAX = 24'h15F900;
  localparam logic [15:0] UNJOINED_RST = 16'h03E8;
  localparam logic [1:0] OPTIONS_RST = 2'h0;
  localparam int OPT_NO_POLL = 0;
  localparam int OPT_NO_SAMPLE = 1;
  localparam logic [17:0] BAUD_RST = 18'h00003;
  localparam logic [17:0] BAUD_STD_MAX = 18'h00008;
  localparam logic [17:0] BAUD_MIN = 18'h004B0;
  localparam logic [17:0] BAUD_MAX = 18'h3D090;
  localparam int CLK_HZ = 40000000;
  localparam int MS_TICK_CYCLES = CLK_HZ / 1000;
  localparam int TEN_MS_TICK_CYCLES = CLK_HZ / 100;
  localparam int RECAL_SECONDS = 15;
  localparam int RECAL_TICKS = RECAL_SECONDS * 100;
  localparam int UART_REF_HZ = 16000000;
endpackage

//--- rtl/rss_tick_gen.sv
/*
 Tick generator: a divider producing a one-cycle pulse every DIV cycles.
 Assumes a free-running clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rss_tick_gen #(
  parameter int DIV = 40000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [25:0] count_reg;
  logic [25:0] count_next;
  logic tick_next;
  always_comb begin
    count_next = count_reg + 26'h0000001;
    tick_next = 1'b0;
    if (count_reg == 26'(DIV - 1)) begin
      count_next = 26'h0000000;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 26'h0000000;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= tick_next;
    end
  end
  chk_tick_single: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

//--- rtl/rss_control.sv
/*
 Radio sleep and settings control: command-indexed configuration store,
 clear channel gate, sleep sequencer, indirect message hold timer and
 power recalibration pacing.
 Assumes the host issues one command per cycle on cmdValid and that
 channel energy arrives from same-clock logic, in -dBm units.
*/
`timescale 1ns/1ps
`default_nettype none
module rss_control #(
  parameter int MS_DIV = rss_pkg::MS_TICK_CYCLES,
  parameter int TEN_MS_DIV = rss_pkg::TEN_MS_TICK_CYCLES,
  parameter int RECAL_TICKS = rss_pkg::RECAL_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [3:0] cmdIndex,
  input wire logic [23:0] cmdData,
  output logic cmdAck,
  output logic cmdError,
  output logic [23:0] rdData,
  input wire logic highPowerVariant,
  input wire logic isCoordinator,
  input wire logic associated,
  input wire logic sampleEnabled,
  input wire logic activity,
  input wire logic pinSleepReq,
  input wire logic pinWake,
  input wire logic pendingData,
  input wire logic txRequest,
  input wire logic [7:0] channelEnergy,
  input wire logic heldMsgStart,
  input wire logic heldMsgTaken,
  output logic txGo,
  output logic txCancel,
  output logic [2:0] txPowerStep,
  output logic boostOn,
  output logic asleep,
  output logic pollReq,
  output logic sampleReq,
  output logic assocRetry,
  output logic recalReq,
  output logic heldDiscard,
  output logic directSend,
  output logic [17:0] uartBaud
);
  typedef enum logic [3:0] {
    SL_AWAKE = 4'b0001,
    SL_SLEEP = 4'b0010,
    SL_WAKE = 4'b0100,
    SL_PIN = 4'b1000
  } rss_sleep_type;

  logic msTick;
  logic tenMsTick;
  // Shared divider instance per time base keeps counters small
  rss_tick_gen #(.DIV(MS_DIV)) msGen (.clk(clk), .rst_n(rst_n), .tick(msTick));
  rss_tick_gen #(.DIV(TEN_MS_DIV)) tenGen (.clk(clk), .rst_n(rst_n), .tick(tenMsTick));

  logic [2:0] txPower_reg, txPower_next;
  logic gain_reg, gain_next;
  logic [7:0] cca_reg, cca_next;
  logic [2:0] sleepMode_reg, sleepMode_next;
  logic [15:0] awake_reg, awake_next;
  logic [23:0] sleepPer_reg, sleepPer_next;
  logic [15:0] unjoined_reg, unjoined_next;
  logic [1:0] options_reg, options_next;
  logic [17:0] baud_reg, baud_next;
  logic ack_next, err_next;
  logic [23:0] rd_next;
  logic [17:0] baudNearest;
  logic [17:0] reqBaud;
  logic [31:0] baudDiv;
  logic [31:0] baudDivNum;

  // Nearest rate reachable from a 16x oversampled reference divider
  always_comb begin
    reqBaud = cmdData[17:0];
    baudDivNum = 32'(rss_pkg::UART_REF_HZ / 16) + 32'(reqBaud[17:1]);
    baudDiv = baudDivNum / 32'(reqBaud);
    if (baudDiv == 32'h00000000) begin
      baudDiv = 32'h00000001;
    end
    baudNearest = 18'((32'(rss_pkg::UART_REF_HZ / 16) + (baudDiv >> 1)) / baudDiv);
  end

  always_comb begin
    txPower_next = txPower_reg;
    gain_next = gain_reg;
    cca_next = cca_reg;
    sleepMode_next = sleepMode_reg;
    awake_next = awake_reg;
    sleepPer_next = sleepPer_reg;
    unjoined_next = unjoined_reg;
    options_next = options_reg;
    baud_next = baud_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    rd_next = rdData;
    if (cmdValid) begin
      ack_next = 1'b1;
      if (cmdWrite) begin
        unique case (cmdIndex)
          // RULE_01: power range check
          rss_pkg::REG_TX_POWER:
            if (cmdData <= 24'(rss_pkg::TX_POWER_MAX)) txPower_next = cmdData[2:0];
            else err_next = 1'b1;
          // RULE_03: boost select
          rss_pkg::REG_GAIN:
            if (cmdData <= 24'h000001) gain_next = cmdData[0];
            else err_next = 1'b1;
          // RULE_05: threshold range
          rss_pkg::REG_CCA:
            if (cmdData >= 24'(rss_pkg::CCA_MIN) && cmdData <= 24'(rss_pkg::CCA_MAX))
              cca_next = cmdData[7:0];
            else err_next = 1'b1;
          // RULE_06: reserved codes rejected
          rss_pkg::REG_SLEEP_MODE:
            if (cmdData == 24'(rss_pkg::SM_NONE) || cmdData == 24'(rss_pkg::SM_PIN) ||
                cmdData == 24'(rss_pkg::SM_CYCLIC) || cmdData == 24'(rss_pkg::SM_CYCLIC_PIN))
              sleepMode_next = cmdData[2:0];
            else err_next = 1'b1;
          // RULE_08: awake window range
          rss_pkg::REG_AWAKE:
            if (cmdData != 24'h000000 && cmdData <= 24'h00FFFF) awake_next = cmdData[15:0];
            else err_next = 1'b1;
          // RULE_09: sleep period limit
          rss_pkg::REG_SLEEP_PER:
            if (cmdData <= rss_pkg::SLEEP_PER_MAX) sleepPer_next = cmdData;
            else err_next = 1'b1;
          // RULE_12: unjoined period range
          rss_pkg::REG_UNJOINED:
            if (cmdData != 24'h000000 && cmdData <= 24'h00FFFF) unjoined_next = cmdData[15:0];
            else err_next = 1'b1;
          rss_pkg::REG_OPTIONS:
            if (cmdData <= 24'h000003) options_next = cmdData[1:0];
            else err_next = 1'b1;
          // RULE_15: nearest achievable rate
          rss_pkg::REG_BAUD:
            if (cmdData <= 24'(rss_pkg::BAUD_STD_MAX)) baud_next = cmdData[17:0];
            else if (cmdData >= 24'(rss_pkg::BAUD_MIN) && cmdData <= 24'(rss_pkg::BAUD_MAX))
              baud_next = baudNearest;
            else err_next = 1'b1;
          default: err_next = 1'b1;
        endcase
      end else begin
        unique case (cmdIndex)
          rss_pkg::REG_TX_POWER: rd_next = 24'(txPower_reg);
          rss_pkg::REG_GAIN: rd_next = 24'(gain_reg);
          rss_pkg::REG_CCA: rd_next = 24'(cca_reg);
          rss_pkg::REG_SLEEP_MODE: rd_next = 24'(sleepMode_reg);
          rss_pkg::REG_AWAKE: rd_next = 24'(awake_reg);
          rss_pkg::REG_SLEEP_PER: rd_next = sleepPer_reg;
          rss_pkg::REG_UNJOINED: rd_next = 24'(unjoined_reg);
          rss_pkg::REG_OPTIONS: rd_next = 24'(options_reg);
          rss_pkg::REG_BAUD: rd_next = 24'(baud_reg);
          rss_pkg::REG_STATUS: rd_next = 24'({asleep, txCancel, heldDiscard});
          default: begin
            rd_next = 24'h000000;
            err_next = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txPower_reg <= rss_pkg::TX_POWER_RST;
      gain_reg <= rss_pkg::GAIN_RST;
      cca_reg <= rss_pkg::CCA_RST;
      sleepMode_reg <= rss_pkg::SM_NONE;
      awake_reg <= rss_pkg::AWAKE_RST;
      sleepPer_reg <= rss_pkg::SLEEP_PER_RST;
      unjoined_reg <= rss_pkg::UNJOINED_RST;
      options_reg <= rss_pkg::OPTIONS_RST;
      baud_reg <= rss_pkg::BAUD_RST;
      cmdAck <= 1'b0;
      cmdError <= 1'b0;
      rdData <= 24'h000000;
    end else begin
      txPower_reg <= txPower_next;
      gain_reg <= gain_next;
      cca_reg <= cca_next;
      sleepMode_reg <= sleepMode_next;
      awake_reg <= awake_next;
      sleepPer_reg <= sleepPer_next;
      unjoined_reg <= unjoined_next;
      options_reg <= options_next;
      baud_reg <= baud_next;
      cmdAck <= ack_next;
      cmdError <= err_next;
      rdData <= rd_next;
    end
  end

  // Sleep and wake pins are asynchronous; two flops before any use
  logic [1:0] sleepPinSync_reg, wakePinSync_reg;
  rss_sleep_type state_reg, state_next;
  logic [23:0] timer_reg, timer_next;
  logic txGo_next, txCancel_next, poll_next, sample_next, retry_next;
  logic cyclic;
  logic [11:0] recal_reg, recal_next;
  logic recal_next_o;
  logic [25:0] hold_reg, hold_next;
  logic holding_reg, holding_next, discard_next;
  logic [2:0] halfCnt_reg, halfCnt_next;

  assign cyclic = (sleepMode_reg == rss_pkg::SM_CYCLIC) ||
                  (sleepMode_reg == rss_pkg::SM_CYCLIC_PIN);

  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    poll_next = 1'b0;
    sample_next = 1'b0;
    retry_next = 1'b0;
    // RULE_04: energy gate
    txGo_next = txRequest && (channelEnergy >= cca_reg);
    txCancel_next = txRequest && (channelEnergy < cca_reg);
    unique case (state_reg)
      SL_AWAKE: begin
        // RULE_07: no sleep stays awake
        if (sleepMode_reg == rss_pkg::SM_PIN && sleepPinSync_reg[1]) begin
          state_next = SL_PIN;
        end else if (cyclic && !isCoordinator) begin
          // RULE_18: awake timer
          if (activity) timer_next = 24'(awake_reg);
          else if (msTick && timer_reg <= 24'h000001) begin
            state_next = SL_SLEEP;
            // RULE_09: sleep duration
            // RULE_12: unjoined duration
            timer_next = associated ? sleepPer_reg : 24'(unjoined_reg);
          end else if (msTick) timer_next = timer_reg - 24'h000001;
        end
      end
      SL_SLEEP: begin
        if (!cyclic) state_next = SL_AWAKE;
        else if ((sleepMode_reg == rss_pkg::SM_CYCLIC_PIN && wakePinSync_reg[1]) ||
                 (tenMsTick && timer_reg <= 24'h000001)) begin
          state_next = SL_WAKE;
        end else if (tenMsTick) timer_next = timer_reg - 24'h000001;
      end
      SL_WAKE: begin
        // RULE_13: poll unless suppressed
        poll_next = associated && !options_reg[rss_pkg::OPT_NO_POLL];
        // RULE_14: sample unless suppressed
        sample_next = sampleEnabled && !options_reg[rss_pkg::OPT_NO_SAMPLE];
        retry_next = !associated;
        // RULE_09: stay up only for pending data
        timer_next = pendingData ? 24'(awake_reg) : 24'h000001;
        state_next = SL_AWAKE;
      end
      SL_PIN: begin
        if (!(sleepMode_reg == rss_pkg::SM_PIN && sleepPinSync_reg[1])) state_next = SL_WAKE;
      end
      default: state_next = SL_AWAKE;
    endcase
  end

  // RULE_02: recalibration pacing
  always_comb begin
    recal_next = recal_reg;
    recal_next_o = 1'b0;
    if (highPowerVariant && tenMsTick) begin
      if (recal_reg == 12'(RECAL_TICKS - 1)) begin
        recal_next = 12'h000;
        recal_next_o = 1'b1;
      end else recal_next = recal_reg + 12'h001;
    end
  end

  // RULE_10: hold for 2.5 periods, counted in 5 ms halves
  always_comb begin
    hold_next = hold_reg;
    holding_next = holding_reg;
    discard_next = 1'b0;
    if (heldMsgStart && sleepPer_reg != 24'h000000) begin
      holding_next = 1'b1;
      // Terminal unit counted as well, so load one less
      hold_next = 26'({sleepPer_reg, 2'b00} + {2'b00, sleepPer_reg} - 26'h0000001);
    end else if (holding_reg && heldMsgTaken) begin
      holding_next = 1'b0;
    end else if (holding_reg && msTick && halfCnt_reg == 3'h4) begin
      // Tick every 5 ms would need a third divider; ms count of 5 per unit instead
      if (hold_reg == 26'h0000000) begin
        holding_next = 1'b0;
        discard_next = 1'b1;
      end else hold_next = hold_reg - 26'h0000001;
    end
  end

  always_comb begin
    halfCnt_next = halfCnt_reg;
    if (!holding_reg || heldMsgStart) halfCnt_next = 3'h0;
    else if (msTick) halfCnt_next = (halfCnt_reg == 3'h4) ? 3'h0 : halfCnt_reg + 3'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SL_AWAKE;
      timer_reg <= 24'(rss_pkg::AWAKE_RST);
      txGo <= 1'b0;
      txCancel <= 1'b0;
      pollReq <= 1'b0;
      sampleReq <= 1'b0;
      assocRetry <= 1'b0;
      asleep <= 1'b0;
      recal_reg <= 12'h000;
      recalReq <= 1'b0;
      hold_reg <= 26'h0000000;
      holding_reg <= 1'b0;
      heldDiscard <= 1'b0;
      halfCnt_reg <= 3'h0;
      sleepPinSync_reg <= 2'b00;
      wakePinSync_reg <= 2'b00;
      txPowerStep <= rss_pkg::TX_POWER_RST;
      boostOn <= rss_pkg::GAIN_RST;
      directSend <= 1'b1;
      uartBaud <= rss_pkg::BAUD_RST;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      txGo <= txGo_next;
      txCancel <= txCancel_next;
      pollReq <= poll_next;
      sampleReq <= sample_next;
      assocRetry <= retry_next;
      asleep <= (state_next == SL_SLEEP) || (state_next == SL_PIN);
      recal_reg <= recal_next;
      recalReq <= recal_next_o;
      hold_reg <= hold_next;
      holding_reg <= holding_next;
      heldDiscard <= discard_next;
      halfCnt_reg <= halfCnt_next;
      sleepPinSync_reg <= {sleepPinSync_reg[0], pinSleepReq};
      wakePinSync_reg <= {wakePinSync_reg[0], pinWake};
      txPowerStep <= txPower_next;
      boostOn <= gain_next;
      // RULE_11: zero period sends direct
      directSend <= isCoordinator && sleepPer_next == 24'h000000;
      // RULE_16: baud drives only the serial port
      uartBaud <= baud_next;
    end
  end

  chk_cca_cancel: assert property (@(posedge clk) disable iff (!rst_n)
    txRequest && channelEnergy < cca_reg |=> txCancel && !txGo) // RULE_04
    else $error("transmission not cancelled above threshold");
  chk_cca_go: assert property (@(posedge clk) disable iff (!rst_n)
    txRequest && channelEnergy >= cca_reg |=> txGo && !txCancel) // RULE_04
    else $error("clear channel transmission blocked");
  chk_power_range: assert property (@(posedge clk) disable iff (!rst_n)
    txPower_reg <= rss_pkg::TX_POWER_MAX) // RULE_01
    else $error("power level out of range");
  chk_cca_range: assert property (@(posedge clk) disable iff (!rst_n)
    cca_reg >= rss_pkg::CCA_MIN && cca_reg <= rss_pkg::CCA_MAX) // RULE_05
    else $error("threshold out of range");
  chk_mode_reject: assert property (@(posedge clk) disable iff (!rst_n)
    cmdValid && cmdWrite && cmdIndex == rss_pkg::REG_SLEEP_MODE &&
    (cmdData == 24'h000002 || cmdData == 24'h000003)
    |=> cmdError && $stable(sleepMode_reg)) // RULE_06
    else $error("reserved sleep code accepted");
  chk_no_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    sleepMode_reg == rss_pkg::SM_NONE && $past(sleepMode_reg) == rss_pkg::SM_NONE
    && !$past(asleep) |-> !asleep) // RULE_07
    else $error("slept with sleep disabled");
  chk_wake_poll: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SL_WAKE && associated |=> pollReq == !$past(options_reg[0])) // RULE_13
    else $error("wake poll option ignored");
  chk_wake_sample: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SL_WAKE && sampleEnabled |=> sampleReq == !$past(options_reg[1])) // RULE_14
    else $error("wake sample option ignored");
  chk_activity_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SL_AWAKE && activity && cyclic && !pinSleepReq
    |=> state_reg == SL_AWAKE ##0 timer_reg == 24'($past(awake_reg))) // RULE_18
    else $error("activity did not restart awake timer");
  chk_direct: assert property (@(posedge clk) disable iff (!rst_n)
    isCoordinator && sleepPer_next == 24'h000000 |=> directSend) // RULE_11
    else $error("coordinator not direct with zero period");
  cov_cancel: cover property (@(posedge clk) disable iff (!rst_n) txCancel);
  cov_sleep: cover property (@(posedge clk) disable iff (!rst_n) $rose(asleep));
  cov_discard: cover property (@(posedge clk) disable iff (!rst_n) heldDiscard);
  cov_baud: cover property (@(posedge clk) disable iff (!rst_n)
    cmdAck && !cmdError && uartBaud > rss_pkg::BAUD_STD_MAX);
endmodule
`default_nettype wire

//--- test/rss_host_model.sv
/*
 Host model: issues one configuration command at a time on the
 command port. Assumes the bench calls send from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module rss_host_model (
  input wire logic clk,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [3:0] cmdIndex,
  output logic [23:0] cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdIndex = 4'h0;
    cmdData = 24'h0;
  end
  task automatic send(input logic w, input logic [3:0] idx, input logic [23:0] d);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdIndex = idx;
    cmdData = d;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    // Stale fields scrambled so the block never leans on them
    cmdIndex = ~idx;
    cmdData = ~d;
  endtask
endmodule
`default_nettype wire

//--- test/radio_sleep_settings_control_tb.sv
/*
 Self-checking bench for rss_control with shortened tick divisors.
 Assumes the host model drives the command port.
*/
`timescale 1ns/1ps
`default_nettype none
module radio_sleep_settings_control_tb;
  logic clk, rst_n, cmdValid, cmdWrite, cmdAck, cmdError;
  logic [3:0] cmdIndex;
  logic [23:0] cmdData, rdData;
  logic highPowerVariant, isCoordinator, associated, sampleEnabled, activity;
  logic pinSleepReq, pinWake, pendingData, txRequest, heldMsgStart, heldMsgTaken;
  logic [7:0] channelEnergy, thr;
  logic txGo, txCancel, boostOn, asleep, pollReq, sampleReq, assocRetry;
  logic recalReq, heldDiscard, directSend;
  logic [2:0] txPowerStep;
  logic [17:0] uartBaud;
  logic [25:0] cmdQ[$];
  logic [1:0] txQ[$];
  logic [25:0] ent;
  logic [31:0] lfsr = 32'h3F25;
  int errors = 0, num_checks = 0;
  int pollCnt, sampleCnt, retryCnt, discardCnt, recalCnt, sleepCnt;
  logic [23:0] rstTab[9] = '{24'h4, 24'h1, 24'h2C, 24'h0, 24'h1388, 24'h0, 24'h3E8,
    24'h0, 24'h3};
  logic [27:0] badTab[15] = '{{4'h0, 24'h5}, {4'h1, 24'h2}, {4'h2, 24'h27},
    {4'h2, 24'h51}, {4'h3, 24'h2}, {4'h3, 24'h3}, {4'h3, 24'h6}, {4'h4, 24'h0},
    {4'h4, 24'h10000}, {4'h5, 24'h15F901}, {4'h6, 24'h0}, {4'h7, 24'h4},
    {4'h8, 24'h9}, {4'hA, 24'h0}, {4'h9, 24'h0}};

  rss_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdIndex(cmdIndex), .cmdData(cmdData));
  rss_control #(.MS_DIV(4), .TEN_MS_DIV(8), .RECAL_TICKS(3)) dut (.clk(clk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdIndex(cmdIndex), .cmdData(cmdData),
    .cmdAck(cmdAck), .cmdError(cmdError), .rdData(rdData),
    .highPowerVariant(highPowerVariant), .isCoordinator(isCoordinator),
    .associated(associated), .sampleEnabled(sampleEnabled), .activity(activity),
    .pinSleepReq(pinSleepReq), .pinWake(pinWake), .pendingData(pendingData),
    .txRequest(txRequest), .channelEnergy(channelEnergy), .heldMsgStart(heldMsgStart),
    .heldMsgTaken(heldMsgTaken), .txGo(txGo), .txCancel(txCancel),
    .txPowerStep(txPowerStep), .boostOn(boostOn), .asleep(asleep), .pollReq(pollReq),
    .sampleReq(sampleReq), .assocRetry(assocRetry), .recalReq(recalReq),
    .heldDiscard(heldDiscard), .directSend(directSend), .uartBaud(uartBaud));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmd(input logic w, input logic [3:0] i, input logic [23:0] d,
    input logic e, input logic [23:0] r);
    cmdQ.push_back({e, ~w, r});
    host.send(w, i, d);
  endtask

  task automatic tx(input logic [7:0] e);
    txQ.push_back((e < thr) ? 2'b01 : 2'b10);
    @(posedge clk);
    #1;
    txRequest = 1'b1;
    channelEnergy = e;
    @(posedge clk);
    #1;
    txRequest = 1'b0;
    channelEnergy = ~e;
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clr();
    {pollCnt, sampleCnt, retryCnt, discardCnt, recalCnt, sleepCnt} = '0;
  endtask

  task automatic waitAsleep(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if (asleep === lvl) break;
    end
    if (n == lim) begin
      errors++;
      $display("BAD asleep wait expected %b", lvl);
      end_of_test();
    end
  endtask

  always @(posedge clk) begin
    #2;
    if (cmdAck === 1'b1) begin
      if (cmdQ.size() == 0) check("cmdAck spare", 24'h1, 24'h0);
      else begin
        ent = cmdQ.pop_front();
        check("cmdError", {23'h0, cmdError}, {23'h0, ent[25]});
        if (ent[24]) check("rdData", rdData, ent[23:0]);
      end
    end
    if (txGo === 1'b1 || txCancel === 1'b1) begin
      if (txQ.size() == 0) check("tx spare", 24'h1, 24'h0);
      else check("txGo txCancel", {22'h0, txGo, txCancel}, {22'h0, txQ.pop_front()});
    end
    pollCnt += (pollReq === 1'b1);
    sampleCnt += (sampleReq === 1'b1);
    retryCnt += (assocRetry === 1'b1);
    discardCnt += (heldDiscard === 1'b1);
    recalCnt += (recalReq === 1'b1);
    sleepCnt += (asleep === 1'b1);
  end

  initial begin
    rst_n = 1'b0;
    {highPowerVariant, isCoordinator, associated, sampleEnabled, activity} = '0;
    {pinSleepReq, pinWake, pendingData, txRequest, heldMsgStart, heldMsgTaken} = '0;
    channelEnergy = 8'h0;
    thr = 8'h2C;
    run(6);
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) cmd(1'b0, i[3:0], 24'h0, 1'b0, rstTab[i]);
    for (int i = 0; i < 15; i++) cmd(1'b1, badTab[i][27:24], badTab[i][23:0], 1'b1, 24'h0);
    for (int i = 0; i < 9; i++) cmd(1'b0, i[3:0], 24'h0, 1'b0, rstTab[i]);
    cmd(1'b1, 4'h0, 24'h0, 1'b0, 24'h0);
    cmd(1'b1, 4'h1, 24'h0, 1'b0, 24'h0);
    cmd(1'b1, 4'h8, 24'h7, 1'b0, 24'h0);
    cmd(1'b1, 4'h3, 24'h5, 1'b0, 24'h0);
    cmd(1'b0, 4'h3, 24'h0, 1'b0, 24'h5);
    cmd(1'b1, 4'h5, 24'h15F900, 1'b0, 24'h0);
    cmd(1'b0, 4'h5, 24'h0, 1'b0, 24'h15F900);
    check("txPowerStep", {21'h0, txPowerStep}, 24'h0);
    check("boostOn", {23'h0, boostOn}, 24'h0);
    // baud only moves the serial rate
    check("uartBaud", {6'h0, uartBaud}, 24'h7);
    cmd(1'b1, 4'h8, 24'h1C200, 1'b0, 24'h0);
    cmd(1'b0, 4'h8, 24'h0, 1'b0, 24'h1B207);
    for (int i = 0; i < 10; i++) begin
      lfsr = nextRand(lfsr);
      thr = (i == 0) ? 8'h28 : (i == 1) ? 8'h50 : 8'h28 + 8'(lfsr % 41);
      cmd(1'b1, 4'h2, {16'h0, thr}, 1'b0, 24'h0);
      cmd(1'b0, 4'h2, 24'h0, 1'b0, {16'h0, thr});
      tx(thr - 8'h1);
      tx(thr);
      tx(lfsr[15:8]);
    end
    cmd(1'b1, 4'h4, 24'h2, 1'b0, 24'h0);
    cmd(1'b1, 4'h5, 24'h2, 1'b0, 24'h0);
    cmd(1'b1, 4'h6, 24'h1, 1'b0, 24'h0);
    {associated, sampleEnabled} = 2'b11;
    cmd(1'b1, 4'h3, 24'h4, 1'b0, 24'h0);
    // Reload the awake timer with the short window
    activity = 1'b1;
    run(1);
    activity = 1'b0;
    clr();
    run(300);
    // sleeps then wakes to poll and sample
    check("poll seen", 24'(pollCnt > 0), 24'h1);
    check("sample seen", 24'(sampleCnt > 0), 24'h1);
    check("slept", 24'(sleepCnt > 0), 24'h1);
    cmd(1'b1, 4'h7, 24'h3, 1'b0, 24'h0);
    run(2);
    clr();
    run(300);
    check("poll skipped", 24'(pollCnt), 24'h0);
    check("sample skipped", 24'(sampleCnt), 24'h0);
    associated = 1'b0;
    clr();
    run(300);
    check("retry seen", 24'(retryCnt > 0), 24'h1);
    activity = 1'b1;
    run(40);
    clr();
    run(100);
    check("activity holds awake", 24'(sleepCnt), 24'h0);
    activity = 1'b0;
    waitAsleep(1'b1, 40);
    cmd(1'b1, 4'h3, 24'h0, 1'b0, 24'h0);
    run(40);
    clr();
    run(100);
    check("mode 0 awake", 24'(sleepCnt), 24'h0);
    cmd(1'b1, 4'h3, 24'h1, 1'b0, 24'h0);
    pinSleepReq = 1'b1;
    waitAsleep(1'b1, 5);
    cmd(1'b0, 4'h9, 24'h0, 1'b0, 24'h4);
    pinSleepReq = 1'b0;
    waitAsleep(1'b0, 5);
    cmd(1'b1, 4'h3, 24'h0, 1'b0, 24'h0);
    isCoordinator = 1'b1;
    cmd(1'b1, 4'h5, 24'h0, 1'b0, 24'h0);
    run(2);
    check("directSend", {23'h0, directSend}, 24'h1);
    cmd(1'b1, 4'h5, 24'h1, 1'b0, 24'h0);
    run(2);
    check("held mode", {23'h0, directSend}, 24'h0);
    // 25 ms hold is 100 cycles here
    clr();
    heldMsgStart = 1'b1;
    run(1);
    heldMsgStart = 1'b0;
    run(94);
    check("early discard", 24'(discardCnt), 24'h0);
    run(12);
    check("discard", 24'(discardCnt), 24'h1);
    clr();
    heldMsgStart = 1'b1;
    run(1);
    heldMsgStart = 1'b0;
    run(5);
    heldMsgTaken = 1'b1;
    run(1);
    heldMsgTaken = 1'b0;
    run(110);
    check("taken kept", 24'(discardCnt), 24'h0);
    clr();
    run(100);
    check("no recal", 24'(recalCnt), 24'h0);
    highPowerVariant = 1'b1;
    run(100);
    check("recal pace", 24'(recalCnt >= 3 && recalCnt <= 5), 24'h1);
    run(4);
    check("queues drained", 24'(cmdQ.size() + txQ.size()), 24'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
